// >>> logic/fisp_regs.sv
// flash programming registers with boot-entry key
`include "fisp_cfg.svh"
module fisp_regs
	import fisp_pkg::*;
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// cpu register port
	input wire fisp_cpu_req_t i_cpu,
	output logic [7:0] o_rdata,
	// hidden operation control from the internal sequencer
	input wire fisp_ctl_req_t i_ctl,
	// instruction-cycle strobe and emulation controls
	input wire logic i_instr_cycle,
	input wire logic i_emul_mode,
	input wire logic i_breakpoint,
	// jump-to-boot instruction executing
	input wire logic i_jump_boot,
	// flash array side
	output fisp_flash_req_t o_flash,
	input wire logic i_flash_done,
	input wire logic [7:0] i_flash_rdata,
	// jump results and operation status
	output logic o_boot_enter,
	output logic o_flash_jump,
	output logic o_fetch_block,
	output logic o_op_done
);
	fisp_state_t s_q;
	fisp_state_t s_d;

	// register select compare, used for writes; reads decode the select directly
	function automatic logic hit(input fisp_cpu_req_t r, input logic [2:0] sel);
		hit = r.sel == sel;
	endfunction

	// next-state logic for every register and the operation sequencer
	always_comb
	begin
		s_d = s_q;
		s_d.flash_start = 1'b0;
		s_d.op_done = 1'b0;
		s_d.boot_enter = 1'b0;
		s_d.flash_jump = 1'b0;
		// cpu writes; key register is write-only and never stored
		if (i_cpu.wr)
		begin
			if (hit(i_cpu, `FISP_SEL_ADDR_HI))
				s_d.addr_hi = i_cpu.wdata;
			if (hit(i_cpu, `FISP_SEL_ADDR_LO))
				s_d.addr_lo = i_cpu.wdata;
			if (hit(i_cpu, `FISP_SEL_RD_BYTE))
				s_d.rd_byte = i_cpu.wdata;
			if (hit(i_cpu, `FISP_SEL_WR_BYTE))
				s_d.wr_byte = i_cpu.wdata;
			// top bit is read-only, so only the low seven are kept
			if (hit(i_cpu, `FISP_SEL_PULSE))
				s_d.pulse = i_cpu.wdata[6:0];
		end
		// unlock counter: counts instruction cycles, frozen on breakpoint in emulation mode
		if (s_q.unlocked && i_instr_cycle && !(i_emul_mode && i_breakpoint))
		begin
			s_d.unlock_cnt = s_q.unlock_cnt - 4'h1;
			if (s_q.unlock_cnt == 4'h1)
				s_d.unlocked = 1'b0;
		end
		// a matching key wins over expiry and restarts the interval
		if (i_cpu.wr && hit(i_cpu, `FISP_SEL_KEY)
			&& i_cpu.wdata[7:2] == `FISP_KEY_PATTERN)
		begin
			s_d.unlocked = 1'b1;
			s_d.unlock_cnt = `FISP_UNLOCK_CYCLES;
		end
		// jump-to-boot goes to boot only while unlocked
		if (i_jump_boot)
		begin
			s_d.boot_enter = s_q.unlocked;
			s_d.flash_jump = !s_q.unlocked;
		end
		// hidden control sequencer; flash fetch blocked while busy
		case (s_q.st)
			FISP_ST_IDLE:
			begin
				if (i_ctl.start)
				begin
					s_d.op = i_ctl.op;
					s_d.flash_start = 1'b1;
					s_d.fetch_block = 1'b1;
					s_d.st = FISP_ST_BUSY;
				end
			end
			FISP_ST_BUSY:
			begin
				if (i_flash_done)
				begin
					if (s_q.op == FISP_OP_READ)
						s_d.rd_byte = i_flash_rdata;
					s_d.st = FISP_ST_DONE;
				end
			end
			FISP_ST_DONE:
			begin
				s_d.op_done = 1'b1;
				s_d.fetch_block = 1'b0;
				s_d.st = FISP_ST_IDLE;
			end
			default:
			begin
				s_d.st = FISP_ST_IDLE;
				s_d.fetch_block = 1'b0;
			end
		endcase
		// registered read data; key reads back zero
		s_d.rdata = 8'h00;
		if (i_cpu.rd)
		begin
			case (i_cpu.sel)
				`FISP_SEL_ADDR_HI: s_d.rdata = s_d.addr_hi;
				`FISP_SEL_ADDR_LO: s_d.rdata = s_d.addr_lo;
				`FISP_SEL_RD_BYTE: s_d.rdata = s_d.rd_byte;
				`FISP_SEL_WR_BYTE: s_d.rdata = s_d.wr_byte;
				`FISP_SEL_PULSE: s_d.rdata = {1'b0, s_d.pulse};
				default: s_d.rdata = 8'h00;
			endcase
		end
	end

	// state register; data bytes get a zero reset even though undefined
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			s_q <= '0;
			s_q.addr_hi <= `FISP_ADDR_RST;
			s_q.addr_lo <= `FISP_ADDR_RST;
			s_q.pulse <= 7'(`FISP_PULSE_RST);
			s_q.unlocked <= 1'b0;
			s_q.unlock_cnt <= 4'h0;
			s_q.st <= FISP_ST_IDLE;
		end
		else
			s_q <= s_d;
	end

	// outputs straight from the state flops; all-ones alias passes through
	assign o_rdata = s_q.rdata;
	assign o_flash.start = s_q.flash_start;
	assign o_flash.op = s_q.op;
	assign o_flash.addr = {s_q.addr_hi, s_q.addr_lo};
	assign o_flash.wdata = s_q.wr_byte;
	assign o_flash.pulse = {1'b0, s_q.pulse};
	assign o_boot_enter = s_q.boot_enter;
	assign o_flash_jump = s_q.flash_jump;
	assign o_fetch_block = s_q.fetch_block;
	assign o_op_done = s_q.op_done;

	// checks
	property p_key_sets;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(i_cpu.wr && i_cpu.sel == `FISP_SEL_KEY && i_cpu.wdata[7:2] == 6'h26)
		|=> (s_q.unlocked && s_q.unlock_cnt == 4'h8);
	endproperty
	a_key_sets: assert property (p_key_sets) else $error("key did not unlock");

	property p_bad_key;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(!s_q.unlocked && i_cpu.wr && i_cpu.sel == `FISP_SEL_KEY
			&& i_cpu.wdata[7:2] != 6'h26) |=> !s_q.unlocked;
	endproperty
	a_bad_key: assert property (p_bad_key) else $error("wrong key unlocked");

	property p_expire;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(s_q.unlocked && s_q.unlock_cnt == 4'h1 && i_instr_cycle && !i_breakpoint
			&& !(i_cpu.wr && i_cpu.sel == `FISP_SEL_KEY)) |=> !s_q.unlocked;
	endproperty
	a_expire: assert property (p_expire) else $error("unlock did not expire");

	property p_freeze;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(s_q.unlocked && i_emul_mode && i_breakpoint && !i_cpu.wr)
		|=> $stable(s_q.unlock_cnt) && s_q.unlocked;
	endproperty
	a_freeze: assert property (p_freeze) else $error("counter moved on breakpoint");

	property p_boot;
		@(posedge i_mclk) disable iff (!i_arst_n)
		i_jump_boot |=> (o_boot_enter == $past(s_q.unlocked)) && (o_flash_jump != o_boot_enter);
	endproperty
	a_boot: assert property (p_boot) else $error("jump target wrong");

	property p_addr;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(i_cpu.wr && i_cpu.sel == `FISP_SEL_ADDR_HI) |=> o_flash.addr[15:8] == $past(i_cpu.wdata);
	endproperty
	a_addr: assert property (p_addr) else $error("address high not loaded");

	property p_rdcap;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(s_q.st == FISP_ST_BUSY && i_flash_done && s_q.op == FISP_OP_READ)
		|=> s_q.rd_byte == $past(i_flash_rdata);
	endproperty
	a_rdcap: assert property (p_rdcap) else $error("read byte not captured");

	property p_pulse_ro;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(i_cpu.rd && i_cpu.sel == `FISP_SEL_PULSE) |=> !o_rdata[7];
	endproperty
	a_pulse_ro: assert property (p_pulse_ro) else $error("pulse top bit set");

	// the written low seven bits must reach the array unchanged
	property p_pulse_wr;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(i_cpu.wr && i_cpu.sel == `FISP_SEL_PULSE)
		|=> o_flash.pulse == {1'b0, $past(i_cpu.wdata[6:0])};
	endproperty
	a_pulse_wr: assert property (p_pulse_wr) else $error("pulse timing not loaded");

	property p_block;
		@(posedge i_mclk) disable iff (!i_arst_n)
		o_flash.start |-> o_fetch_block;
	endproperty
	a_block: assert property (p_block) else $error("fetch not blocked");

	c_unlock: cover property (@(posedge i_mclk) disable iff (!i_arst_n) $rose(s_q.unlocked));
	c_boot: cover property (@(posedge i_mclk) disable iff (!i_arst_n) o_boot_enter);
	c_jump: cover property (@(posedge i_mclk) disable iff (!i_arst_n) o_flash_jump);
	c_done: cover property (@(posedge i_mclk) disable iff (!i_arst_n) o_op_done);
endmodule // fisp_regs

// >>> shared/fisp_cfg.svh
// constants for the flash programming register block
// Contract
// - six programming registers, control register hidden
// - address is 16 bits, high and low
// - option byte lives at top flash address
// - reset clears both address registers
// - read byte register captures read result
// - write byte register supplies programmed byte
// - registers reachable from flash or boot code
// - pulse timing value sets pulse width
// - reset loads top-band timing code
// - jump-to-boot and return instructions, no flash fetch
// - key pattern in bits 7..2 sets unlock
// - unlock lasts exactly eight instruction cycles
// - jump enters boot only while unlocked
// - breakpoint freezes unlock counter in emulation
`ifndef FISP_CFG_SVH
`define FISP_CFG_SVH
`define FISP_SEL_ADDR_HI 3'h0
`define FISP_SEL_ADDR_LO 3'h1
`define FISP_SEL_RD_BYTE 3'h2
`define FISP_SEL_WR_BYTE 3'h3
`define FISP_SEL_PULSE 3'h4
`define FISP_SEL_KEY 3'h5
`define FISP_ADDR_RST 8'h00
`define FISP_PULSE_RST 8'h7B
`define FISP_PULSE_RO_BIT 7
`define FISP_KEY_PATTERN 6'h26
`define FISP_UNLOCK_CYCLES 4'h8
`define FISP_OPTION_ALIAS 16'hFFFF
`define FISP_OPTION_PHYS 16'h7FFF
`endif

// >>> shared/fisp_pkg.sv
// types for the flash programming register block
package fisp_pkg;
	typedef enum logic [2:0]
	{
		FISP_ST_IDLE = 3'b001,
		FISP_ST_BUSY = 3'b010,
		FISP_ST_DONE = 3'b100
	} fisp_op_st_t;

	typedef enum logic [1:0]
	{
		FISP_OP_READ = 2'h0,
		FISP_OP_WRITE = 2'h1,
		FISP_OP_PAGE_ERASE = 2'h2,
		FISP_OP_MASS_ERASE = 2'h3
	} fisp_op_t;

	// cpu register access bundle
	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [2:0] sel;
		logic [7:0] wdata;
	} fisp_cpu_req_t;

	// hidden operation control request, driven by internal sequencer
	typedef struct packed
	{
		logic start;
		fisp_op_t op;
	} fisp_ctl_req_t;

	// request toward the flash array
	typedef struct packed
	{
		logic start;
		fisp_op_t op;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic [7:0] pulse;
	} fisp_flash_req_t;

	// whole module state
	typedef struct packed
	{
		logic [7:0] addr_hi;
		logic [7:0] addr_lo;
		logic [7:0] rd_byte;
		logic [7:0] wr_byte;
		logic [6:0] pulse;
		logic [3:0] unlock_cnt;
		logic unlocked;
		fisp_op_st_t st;
		fisp_op_t op;
		logic flash_start;
		logic op_done;
		logic [7:0] rdata;
		logic boot_enter;
		logic flash_jump;
		logic fetch_block;
	} fisp_state_t;
endpackage

// >>> testbench/fisp_regs_tb.sv
// self-checking bench for the flash programming register block
`include "fisp_cfg.svh"
module fisp_regs_tb
	import fisp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_mclk, i_arst_n, i_instr_cycle, i_emul_mode, i_breakpoint, i_jump_boot;
	logic i_flash_done, o_boot_enter, o_flash_jump, o_fetch_block, o_op_done;
	logic [7:0] i_flash_rdata, o_rdata;
	fisp_cpu_req_t i_cpu;
	fisp_ctl_req_t i_ctl;
	fisp_flash_req_t o_flash;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;

	fisp_regs fisp_regs_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_cpu(i_cpu),
		.o_rdata(o_rdata), .i_ctl(i_ctl), .i_instr_cycle(i_instr_cycle),
		.i_emul_mode(i_emul_mode), .i_breakpoint(i_breakpoint), .i_jump_boot(i_jump_boot),
		.o_flash(o_flash), .i_flash_done(i_flash_done), .i_flash_rdata(i_flash_rdata),
		.o_boot_enter(o_boot_enter), .o_flash_jump(o_flash_jump),
		.o_fetch_block(o_fetch_block), .o_op_done(o_op_done));

	// 20 MHz clock
	initial
	begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end

	// hang guard, the whole run needs under two hundred cycles
	always @(posedge i_mclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fail_count++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			fail_count++;
		end
	endtask

	// one-cycle write strobe; a gap cycle follows so strobes never collide
	task automatic wr(input logic [2:0] s, input logic [7:0] d);
		@(posedge i_mclk) #1 i_cpu = '{1'b1, 1'b0, s, d};
		@(posedge i_mclk) #1 i_cpu = '0;
	endtask

	// read data is registered, so it stands in the cycle after the strobe
	task automatic rd(input logic [2:0] s, input logic [7:0] exp, input string nm);
		@(posedge i_mclk) #1 i_cpu = '{1'b0, 1'b1, s, 8'h00};
		@(posedge i_mclk) #1 i_cpu = '0;
		chk(nm, {8'h00, exp}, {8'h00, o_rdata});
	endtask

	task automatic ticks(input int n);
		repeat (n)
		begin
			@(posedge i_mclk) #1 i_instr_cycle = 1'b1;
			@(posedge i_mclk) #1 i_instr_cycle = 1'b0;
		end
	endtask

	task automatic jump(input logic boot);
		@(posedge i_mclk) #1 i_jump_boot = 1'b1;
		@(posedge i_mclk) #1 i_jump_boot = 1'b0;
		chk("boot_enter", {15'h0000, boot}, {15'h0000, o_boot_enter});
		chk("flash_jump", {15'h0000, !boot}, {15'h0000, o_flash_jump});
	endtask

	// start an operation, check what reaches the array, then finish it
	task automatic op(input fisp_op_t o, input logic [15:0] a, input logic [7:0] d);
		@(posedge i_mclk) #1 i_ctl = '{1'b1, o};
		@(posedge i_mclk) #1 i_ctl = '0;
		chk("flash_start", 16'h0001, {15'h0000, o_flash.start});
		chk("flash_op", {14'h0000, o}, {14'h0000, o_flash.op});
		chk("flash_addr", a, o_flash.addr);
		chk("flash_wdata", 16'h00a5, {8'h00, o_flash.wdata});
		chk("flash_pulse", 16'h002f, {8'h00, o_flash.pulse});
		chk("fetch_block", 16'h0001, {15'h0000, o_fetch_block});
		@(posedge i_mclk) #1 i_flash_done = 1'b1;
		i_flash_rdata = d;
		@(posedge i_mclk) #1 i_flash_done = 1'b0;
		for (int k = 0; k < 6 && o_op_done !== 1'b1; k++)
		begin
			@(posedge i_mclk) #1;
		end
		chk("op_done", 16'h0001, {15'h0000, o_op_done});
		chk("fetch_idle", 16'h0000, {15'h0000, o_fetch_block});
	endtask

	// main sequence
	initial
	begin
		i_arst_n = 1'b0;
		i_cpu = '0;
		i_ctl = '0;
		i_instr_cycle = 1'b0;
		i_emul_mode = 1'b0;
		i_breakpoint = 1'b0;
		i_jump_boot = 1'b0;
		i_flash_done = 1'b0;
		i_flash_rdata = 8'h00;
		repeat (5) @(posedge i_mclk);
		#1 i_arst_n = 1'b1;
		rd(`FISP_SEL_ADDR_HI, 8'h00, "addr_hi");
		rd(`FISP_SEL_ADDR_LO, 8'h00, "addr_lo");
		rd(`FISP_SEL_PULSE, 8'h7b, "pulse_rst");
		wr(`FISP_SEL_PULSE, 8'hff);
		rd(`FISP_SEL_PULSE, 8'h7f, "pulse_ro");
		wr(3'h6, 8'h5a);
		rd(3'h6, 8'h00, "unmapped");
		wr(`FISP_SEL_ADDR_HI, 8'h12);
		wr(`FISP_SEL_ADDR_LO, 8'h34);
		wr(`FISP_SEL_WR_BYTE, 8'ha5);
		// a listed band code, loaded once before any write or erase
		wr(`FISP_SEL_PULSE, 8'h2f);
		rd(`FISP_SEL_ADDR_HI, 8'h12, "addr_hi_rw");
		rd(`FISP_SEL_ADDR_LO, 8'h34, "addr_lo_rw");
		rd(`FISP_SEL_WR_BYTE, 8'ha5, "wr_byte_rw");
		wr(`FISP_SEL_RD_BYTE, 8'h3c);
		rd(`FISP_SEL_RD_BYTE, 8'h3c, "rd_byte_rw");
		// address, write byte and pulse registers stay untouched while each operation runs
		op(FISP_OP_READ, 16'h1234, 8'h00);
		op(FISP_OP_WRITE, 16'h1234, 8'h00);
		// page erase takes the page start, mass erase takes zero
		wr(`FISP_SEL_ADDR_LO, 8'h00);
		op(FISP_OP_PAGE_ERASE, 16'h1200, 8'h00);
		wr(`FISP_SEL_ADDR_HI, 8'h00);
		op(FISP_OP_MASS_ERASE, 16'h0000, 8'h00);
		wr(`FISP_SEL_ADDR_HI, 8'hff);
		wr(`FISP_SEL_ADDR_LO, 8'hff);
		op(FISP_OP_READ, 16'hffff, 8'h5a);
		rd(`FISP_SEL_RD_BYTE, 8'h5a, "rd_byte");
		// no interrupt source here, so nothing steals cycles before the jump
		wr(`FISP_SEL_KEY, 8'h9b);
		rd(`FISP_SEL_KEY, 8'h00, "key_read");
		ticks(6);
		jump(1'b1);
		wr(`FISP_SEL_KEY, 8'h98);
		ticks(8);
		jump(1'b0);
		wr(`FISP_SEL_KEY, 8'h9c);
		jump(1'b0);
		wr(`FISP_SEL_KEY, 8'h99);
		ticks(5);
		wr(`FISP_SEL_KEY, 8'h9a);
		ticks(7);
		jump(1'b1);
		wr(`FISP_SEL_KEY, 8'h98);
		i_emul_mode = 1'b1;
		i_breakpoint = 1'b1;
		ticks(10);
		i_emul_mode = 1'b0;
		i_breakpoint = 1'b0;
		ticks(6);
		jump(1'b1);
		close_out();
	end
endmodule // fisp_regs_tb
